/* core/ecc_agp_error_status_flags.sv */
`timescale 1ns/100ps
`include "ecc_err_consts.svh"

// How it works
// - Bad aperture translation entry on graphics access sets status bit 2.
// - Bit 2 resets to 0 and clears only on a software write of one.
// - Malformed or unsupported graphics command sets bit 1; write one clears.
// - Corrected single-bit ECC read returns corrected data and sets bit 0.
// - Setting single-bit flag captures address, channel and device into log.
// - While single-bit flag set, later single-bit errors leave log untouched.
// - Multi-bit error overwrites log even when single-bit flag set; sets bit 7.
// - Writing one to bit 0 clears it and unlocks the log.
// - Flags set regardless of message reporting enables.
// - Enabled 0-to-1 flag transitions send one error message to the link.
// - Bit 7 locks the log until cleared; bits 7 and 0 tell error kind.
module ecc_agp_error_status_flags
  import ecc_err_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Error events
  input  wire logic        badXlateEv,
  input  wire logic        badCmdEv,
  input  wire logic        sbeEv,
  input  wire logic        mbeEv,
  input  wire logic [31:0] errAddr,
  input  wire logic [1:0]  errChan,
  input  wire logic [2:0]  errDev,
  // Read data correction
  input  wire logic [63:0] rdDataRaw,
  input  wire logic [63:0] rdSyndromeFix,
  output logic [63:0]      rdDataOut,
  // Error message to link
  output logic             errMsgReq,
  input  wire logic        errMsgAck,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic [1:0] rstSync_ff;
  logic       rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_ff <= `RST_SYNC_INIT;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_ff[1];

  // ==========================================================
  // Bus decode
  // ==========================================================
  regs_state_t state_ff;
  regs_state_t nxt_state;
  err_evt_t    ev;

  logic        wrEn;
  logic        rdEn;
  logic        hitSts;
  logic        hitCmd;
  logic        hitLogA;
  logic        hitLogI;
  logic        hitMask;
  logic        hitGlob;
  logic        hitAny;
  logic [15:0] w1c;

  assign ev.sbe      = sbeEv;
  assign ev.mbe      = mbeEv;
  assign ev.badXlate = badXlateEv;
  assign ev.badCmd   = badCmdEv;
  assign ev.sig      = '{addr: errAddr, chan: errChan, dev: errDev};

  assign hitSts  = (paddr == `ADDR_STATUS);
  assign hitCmd  = (paddr == `ADDR_MSG_EN);
  assign hitLogA = (paddr == `ADDR_LOG_ADDR);
  assign hitLogI = (paddr == `ADDR_LOG_INFO);
  assign hitMask = (paddr == `ADDR_IRQ_MASK);
  assign hitGlob = (paddr == `ADDR_GLOBAL);
  assign hitAny  = hitSts | hitCmd | hitLogA | hitLogI | hitMask | hitGlob;

  // Zero-wait slave; access phase completes in its first cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hitAny;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & ~penable & ~pwrite;
  assign w1c     = (wrEn & hitSts) ? pwdata[15:0] : 16'h0000;

  // ==========================================================
  // Sticky flags
  // ==========================================================
  logic [3:0] setVec;
  logic [3:0] clrVec;
  logic [3:0] flagVec;
  logic [3:0] riseVec;
  logic [3:0] enVec;

  assign setVec = {ev.mbe, ev.badXlate, ev.badCmd, ev.sbe};
  assign clrVec = {w1c[`BIT_MBE], w1c[`BIT_BADXLATE],
                   w1c[`BIT_BADCMD], w1c[`BIT_SBE]};
  assign enVec  = {state_ff.cmd[`CMD_BIT_MBE],
                   state_ff.cmd[`CMD_BIT_BADXL],
                   state_ff.cmd[`CMD_BIT_BADCMD],
                   state_ff.cmd[`CMD_BIT_SBE]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      flag_cell u_flag (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .setEv     (setVec[gi]),
        .clrEv     (clrVec[gi]),
        .flag      (flagVec[gi]),
        .rise      (riseVec[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  // ==========================================================
  logic sbeLocked;
  logic mbeLocked;

  assign sbeLocked = flagVec[0];
  assign mbeLocked = flagVec[3];

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sts = 16'h0000;
    nxt_state.sts[`BIT_SBE]     = flagVec[0];
    nxt_state.sts[`BIT_BADCMD]  = flagVec[1];
    nxt_state.sts[`BIT_BADXLATE] = flagVec[2];
    nxt_state.sts[`BIT_MBE]     = flagVec[3];

    // Multi-bit signature wins over any single-bit capture
    if (ev.mbe && !mbeLocked) begin
      nxt_state.log = ev.sig;
    end else if (ev.sbe && !sbeLocked && !mbeLocked) begin
      nxt_state.log = ev.sig;
    end

    // One pending message per enabled rising edge; extra edges merge
    if (state_ff.globalEn && |(riseVec & enVec)) begin
      nxt_state.msgPend = 1'b1;
    end else if (errMsgAck) begin
      nxt_state.msgPend = 1'b0;
    end

    if (wrEn && hitCmd) begin
      nxt_state.cmd = pwdata[15:0] & `CMD_IMPL_MASK;
    end
    if (wrEn && hitMask) begin
      nxt_state.mask = pwdata[15:0] & `STS_IMPL_MASK;
    end
    if (wrEn && hitGlob) begin
      nxt_state.globalEn = pwdata[0];
    end

    // Read data registered in setup so it is stable in access phase
    if (rdEn) begin
      nxt_state.rdata = 32'h0000_0000;
      if (hitSts) begin
        // Live flags, so a read right after an event already sees it
        nxt_state.rdata[15:0] = nxt_state.sts;
      end
      if (hitCmd) begin
        nxt_state.rdata[15:0] = state_ff.cmd;
      end
      if (hitLogA) begin
        nxt_state.rdata = state_ff.log.addr;
      end
      if (hitLogI) begin
        nxt_state.rdata[4:0] = {state_ff.log.chan, state_ff.log.dev};
      end
      if (hitMask) begin
        nxt_state.rdata[15:0] = state_ff.mask;
      end
      if (hitGlob) begin
        nxt_state.rdata[0] = state_ff.globalEn;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic [63:0] rdData_ff;

  // Corrected word is the raw word with the flipped bit restored
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdData_ff <= 64'h0000_0000_0000_0000;
    end else begin
      rdData_ff <= rdDataRaw ^ rdSyndromeFix;
    end
  end

  assign rdDataOut = rdData_ff;
  assign prdata    = state_ff.rdata;
  assign errMsgReq = state_ff.msgPend;
  assign irq       = |(state_ff.sts & state_ff.mask);

endmodule

/* core/flag_cell.sv */
`timescale 1ns/100ps
`include "ecc_err_consts.svh"

// One write-one-to-clear sticky flag; a set always beats a clear
module flag_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstSync_n,
  // Control
  input  wire logic setEv,
  input  wire logic clrEv,
  // State
  output logic      flag,
  output logic      rise
);

  typedef struct packed {
    logic flag;
  } cell_t;

  cell_t state_ff;
  cell_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (setEv) begin
      nxt_state.flag = 1'b1;
    end else if (clrEv) begin
      nxt_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flag = state_ff.flag;
  assign rise = setEv & ~state_ff.flag;

endmodule

/* include/ecc_err_consts.svh */
`ifndef ECC_ERR_CONSTS_SVH
`define ECC_ERR_CONSTS_SVH

// Register byte addresses
`define ADDR_STATUS     12'h0C8
`define ADDR_MSG_EN     12'h0CC
`define ADDR_LOG_ADDR   12'h0D0
`define ADDR_LOG_INFO   12'h0D4
`define ADDR_IRQ_MASK   12'h0D8
`define ADDR_GLOBAL     12'h0DC

// Status bit positions
`define BIT_SBE         0
`define BIT_BADCMD      1
`define BIT_BADXLATE    2
`define BIT_MBE         7

// Implemented status and message-enable bits
`define STS_IMPL_MASK   16'h0087
`define STS_RESET       16'h0000
`define CMD_IMPL_MASK   16'h0186
`define CMD_BIT_MBE     8
`define CMD_BIT_SBE     7
`define CMD_BIT_BADCMD  1
`define CMD_BIT_BADXL   2

// Log widths and reset synchronizer start value
`define LOG_ADDR_W      32
`define LOG_CHAN_W      2
`define LOG_DEV_W       3
`define RST_SYNC_INIT   2'h0

`endif

/* include/ecc_err_pkg.sv */
package ecc_err_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  chan;
    logic [2:0]  dev;
  } err_sig_t;

  typedef struct packed {
    logic        sbe;
    logic        mbe;
    logic        badXlate;
    logic        badCmd;
    err_sig_t    sig;
  } err_evt_t;

  typedef struct packed {
    logic [15:0] sts;
    logic [15:0] cmd;
    logic [15:0] mask;
    logic        globalEn;
    err_sig_t    log;
    logic        msgPend;
    logic [31:0] rdata;
  } regs_state_t;

endpackage

/* tb/ecc_agp_error_status_flags_assertions.sv */
`timescale 1ns/100ps
`include "ecc_err_consts.svh"

module ecc_flags_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Events, data, message
  input wire logic        badXlateEv,
  input wire logic        badCmdEv,
  input wire logic        sbeEv,
  input wire logic        mbeEv,
  input wire logic [63:0] rdDataRaw,
  input wire logic [63:0] rdSyndromeFix,
  input wire logic [63:0] rdDataOut,
  input wire logic        errMsgReq,
  input wire logic        errMsgAck
);
  // ==========
  // Settling
  // Core sits two edges behind rst_n
  logic [2:0] upCnt_ff;
  logic       live;
  assign live = upCnt_ff == 3'h7;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) upCnt_ff <= 3'h0;
    else if (!live) upCnt_ff <= upCnt_ff + 3'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========
  // Status access
  // q blocks a set racing the access
  sequence s_rd(q);
    live && psel && !penable && !pwrite && paddr == `ADDR_STATUS && !q
    ##1 psel && penable;
  endsequence
  sequence s_wr(b, q);
    live && psel && penable && pwrite && paddr == `ADDR_STATUS
    && pwdata[b] && !q;
  endsequence

  // ==========
  // Properties
  property p_xlateSet; badXlateEv ##1 s_rd(1'b0) |-> prdata[2]; endproperty
  a_xlateSet: assert property (p_xlateSet)
    else $error("xlate flag not set");
  property p_cmdSet; badCmdEv ##1 s_rd(1'b0) |-> prdata[1]; endproperty
  a_cmdSet: assert property (p_cmdSet)
    else $error("command flag not set");
  property p_sbeSet; sbeEv ##1 s_rd(1'b0) |-> prdata[0]; endproperty
  a_sbeSet: assert property (p_sbeSet)
    else $error("single bit flag not set");
  property p_mbeSet; mbeEv ##1 s_rd(1'b0) |-> prdata[7]; endproperty
  a_mbeSet: assert property (p_mbeSet)
    else $error("multi bit flag not set");
  property p_sbeClr; s_wr(0, sbeEv) ##1 s_rd(sbeEv) |-> !prdata[0];
  endproperty
  a_sbeClr: assert property (p_sbeClr)
    else $error("single bit flag not cleared");
  property p_xlateClr; s_wr(2, badXlateEv) ##1 s_rd(badXlateEv) |-> !prdata[2];
  endproperty
  a_xlateClr: assert property (p_xlateClr)
    else $error("xlate flag not cleared");
  property p_corrData;
    live |-> rdDataOut == ($past(rdDataRaw) ^ $past(rdSyndromeFix));
  endproperty
  a_corrData: assert property (p_corrData)
    else $error("corrected data wrong");
  property p_msgHold; errMsgReq && !errMsgAck |=> errMsgReq; endproperty
  a_msgHold: assert property (p_msgHold)
    else $error("message dropped");
endmodule

bind ecc_agp_error_status_flags ecc_flags_chk ecc_flags_chk_i (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .badXlateEv, .badCmdEv, .sbeEv, .mbeEv, .rdDataRaw, .rdSyndromeFix,
  .rdDataOut, .errMsgReq, .errMsgAck);

/* tb/ecc_agp_error_status_flags_test.sv */
`timescale 1ns/100ps
`include "ecc_err_consts.svh"

module ecc_agp_error_status_flags_test;
  // ==========
  // Signals
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        errMsgReq, errMsgAck, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, errAddr, logA, keep;
  logic [3:0]  evs;
  logic [1:0]  errChan;
  logic [2:0]  errDev;
  logic [63:0] rdDataRaw, rdSyndromeFix, rdDataOut, r;
  logic [31:0] expQ[$];
  int          seed = 95346;
  int          failures = 0;
  int          comparisons = 0;

  ecc_agp_error_status_flags ecc_agp_error_status_flags_i (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .badXlateEv(evs[0]), .badCmdEv(evs[1]),
    .sbeEv(evs[2]), .mbeEv(evs[3]), .errAddr, .errChan, .errDev,
    .rdDataRaw, .rdSyndromeFix, .rdDataOut, .errMsgReq, .errMsgAck, .irq);

  // ==========
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  // Request stays up; caller chains or releases
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expQ.push_back(d);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
  endtask
  task rel;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task ev(input logic [3:0] v);
    logA = $random(seed);
    evs <= v;
    errAddr <= logA;
    {errChan, errDev} <= logA[4:0];
    @(posedge clk);
    evs <= 4'h0;
  endtask
  task look(input logic e);
    repeat (2) @(negedge clk);
    chk({62'h0, irq, errMsgReq}, {62'h0, e, 1'b0});
    @(posedge clk);
  endtask
  task finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready && expQ.size() > 0)
      chk({32'h0, prdata}, {32'h0, expQ.pop_front()});
    if (psel && penable && pready)
      chk({63'h0, pslverr}, {63'h0, paddr == 12'h0E0});
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    finish_test;
  end

  initial begin
    {psel, penable, pwrite, errMsgAck, paddr, pwdata} = '0;
    {evs, errAddr, errChan, errDev, rdDataRaw, rdSyndromeFix} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, `ADDR_STATUS, 32'h0);
    apb(0, `ADDR_LOG_ADDR, 32'h0);
    apb(0, 12'h0E0, 32'h0);
    rel;
    $display("test reset done");
    ev(4'h4);
    keep = logA;
    apb(0, `ADDR_STATUS, 32'h1);
    apb(0, `ADDR_LOG_ADDR, logA);
    apb(0, `ADDR_LOG_INFO, {27'h0, logA[4:0]});
    rel;
    ev(4'h4);
    apb(0, `ADDR_LOG_ADDR, keep);
    rel;
    ev(4'h8);
    keep = logA;
    apb(0, `ADDR_STATUS, 32'h81);
    apb(0, `ADDR_LOG_ADDR, logA);
    rel;
    ev(4'h4);
    apb(0, `ADDR_LOG_ADDR, keep);
    apb(1, `ADDR_STATUS, 32'h81);
    apb(0, `ADDR_STATUS, 32'h0);
    rel;
    ev(4'h4);
    apb(0, `ADDR_LOG_ADDR, logA);
    apb(1, `ADDR_STATUS, 32'h1);
    rel;
    $display("test log done");
    ev(4'h3);
    apb(0, `ADDR_STATUS, 32'h6);
    apb(1, `ADDR_IRQ_MASK, 32'h4);
    rel;
    look(1'b1);
    apb(1, `ADDR_IRQ_MASK, 32'h2);
    apb(1, `ADDR_STATUS, 32'h6);
    apb(0, `ADDR_STATUS, 32'h0);
    rel;
    look(1'b0);
    fork
      apb(1, `ADDR_STATUS, 32'h4);
      begin
        @(posedge clk);
        ev(4'h1);
      end
    join
    apb(0, `ADDR_STATUS, 32'h4);
    apb(1, `ADDR_STATUS, 32'h4);
    apb(0, `ADDR_STATUS, 32'h0);
    apb(1, `ADDR_MSG_EN, 32'h2);
    apb(1, `ADDR_GLOBAL, 32'h1);
    rel;
    $display("test flags done");
    ev(4'h2);
    repeat (3) @(negedge clk);
    chk({63'h0, errMsgReq}, 64'h1);
    @(posedge clk);
    errMsgAck <= 1'b1;
    @(posedge clk);
    errMsgAck <= 1'b0;
    look(1'b1);
    $display("test message done");
    repeat (4) begin
      r = {$random(seed), $random(seed)};
      rdDataRaw <= r;
      rdSyndromeFix <= 64'h1 << r[5:0];
      @(posedge clk);
      @(negedge clk);
      chk(rdDataOut, r ^ (64'h1 << r[5:0]));
      @(posedge clk);
    end
    $display("test data done");
    finish_test;
  end
endmodule
